/* File: design/rars_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module rars_sequencer
  import rars_pkg::*;
#(
  parameter int PH1_DIV = RARS_PH1_DIV  // pclk cycles per phase-one pulse
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        comparator_in,
  input  wire logic        auto_zero_active,
  output rars_drive_type   drive,
  output rars_decoder_type decoder,
  output logic      [15:0] display_value,
  output logic             display_sign_neg,
  output logic      [1:0]  remote_status_code,
  output logic             measure_done,
  output logic      [2:0]  range
);

  // ============================================================
  // Declarations
  rars_state_type   state_r;             // Sequencer state
  rars_result_type  result_r;            // Classified result
  rars_decoder_type dec_r;               // Over/under decoder outputs
  logic [15:0]      count_r;             // Main counter, BCD
  logic [15:0]      elapsed_r;           // Counts since ramp start, BCD
  logic             sign_neg_r;          // Sign latch, 1 = negative
  logic [2:0]       range_r;             // Range counter
  logic             log_mode_select_r;   // Log-mode select
  logic             auto_range_r;        // Auto-range enable
  logic             start_r;             // Pending start request
  logic [16:0]      preset_r;            // {sign, BCD} preset value
  logic             ramp_enable_instr;   // Issued ramp enable
  logic             ramp_held_r;         // Phase-two held ramp enable
  logic             count_instr;         // Issued count
  logic             count_half_r;        // Every-other phase-one toggle
  logic [7:0]       div_r;               // Phase-one divider
  logic             ph1_tick;            // Phase-one falling half
  logic             ph2_tick;            // Phase-two pulse
  logic             cmp_s1_r;            // Comparator sync stage 1
  logic             cmp_r;               // Comparator synchronised
  logic [15:0]      disp_r;              // Display registers
  logic             disp_sign_r;         // Display sign latch
  logic [1:0]       rem_code_r;          // Remote status code
  logic             done_r;              // Completion pulse
  logic             apb_wr;              // APB write strobe
  logic             at_zero;             // Counter reads 0000
  logic             count_down;          // Counting towards zero

  // ============================================================
  // BCD step of one four-digit value, up or down
  function automatic logic [15:0] bcd_step(input logic [15:0] v, input logic dn);
    logic [15:0] r;
    logic        carry;
    r     = v;
    carry = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (carry) begin
        if (dn) begin
          carry       = (v[i*4 +: 4] == 4'h0);
          r[i*4 +: 4] = carry ? 4'h9 : v[i*4 +: 4] - 4'h1;
        end else begin
          carry       = (v[i*4 +: 4] == 4'h9);
          r[i*4 +: 4] = carry ? 4'h0 : v[i*4 +: 4] + 4'h1;
        end
      end
    end
    return r;
  endfunction

  // ============================================================
  // Clock phases
  // Phase-one divider; phase-two follows one pclk later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 8'h00;
    end else if (div_r == 8'(PH1_DIV - 1)) begin
      div_r <= 8'h00;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  assign ph1_tick = (div_r == 8'h00);
  assign ph2_tick = (div_r == 8'h01);

  // Comparator synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_s1_r <= 1'b0;
      cmp_r    <= 1'b0;
    end else begin
      cmp_s1_r <= comparator_in;
      cmp_r    <= cmp_s1_r;
    end
  end

  // ============================================================
  // Instructions during ramp-down
  // Ramp enable every phase-one; stopped once a result registers
  assign ramp_enable_instr = (state_r == RARS_RAMP) && ph1_tick;
  // Count only on every second phase-one pulse
  assign count_instr = ramp_enable_instr && count_half_r;

  // Every-other toggle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_half_r <= 1'b0;
    end else if (state_r != RARS_RAMP) begin
      count_half_r <= 1'b0;
    end else if (ph1_tick) begin
      count_half_r <= ~count_half_r;
    end
  end

  // Held ramp enable, taken on phase two
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp_held_r <= 1'b0;
    end else if (ph2_tick) begin
      ramp_held_r <= (state_r == RARS_RAMP);
    end
  end

  // Drive gating by sign and log select
  always_comb begin
    drive.ramp_pos_drive = ramp_held_r && !log_mode_select_r && !sign_neg_r;
    drive.ramp_neg_drive = ramp_held_r && !log_mode_select_r && sign_neg_r;
    drive.log_ramp_drive = ramp_held_r && log_mode_select_r;
    drive.log_threshold_select = log_mode_select_r && !auto_zero_active;
  end

  // ============================================================
  // Main counter and sign latch
  assign at_zero    = (count_r == RARS_ZERO_CNT);
  assign count_down = log_mode_select_r && sign_neg_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r    <= RARS_ZERO_CNT;
      sign_neg_r <= 1'b0;
      elapsed_r  <= RARS_ZERO_CNT;
    end else if (state_r == RARS_CLEAR) begin
      count_r    <= RARS_ZERO_CNT;
      sign_neg_r <= 1'b0;
      elapsed_r  <= RARS_ZERO_CNT;
    end else if (state_r == RARS_PRESET) begin
      count_r    <= preset_r[15:0];
      sign_neg_r <= preset_r[16];
    end else if (count_instr) begin
      elapsed_r <= bcd_step(elapsed_r, 1'b0);
      if (count_down && at_zero) begin
        // Borrow through zero flips sign and direction
        count_r    <= 16'h0001;
        sign_neg_r <= 1'b0;
      end else begin
        count_r <= bcd_step(count_r, count_down);
      end
    end
  end

  // ============================================================
  // Sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r  <= RARS_IDLE;
      result_r <= RARS_RES_IN;
      range_r  <= RARS_RANGE_RST;
    end else begin
      case (state_r)
        RARS_IDLE: begin
          if (start_r) begin
            state_r <= RARS_CLEAR;
          end
        end
        RARS_CLEAR: begin
          state_r <= log_mode_select_r ? RARS_PRESET : RARS_RAMP;
        end
        RARS_PRESET: begin
          state_r <= RARS_SAMPLE;
        end
        RARS_SAMPLE: begin
          // Low comparator is log under-range
          if (!cmp_r) begin
            result_r <= RARS_RES_UNDER;
            state_r  <= RARS_CLR_RANGE;
          end else begin
            state_r <= RARS_RAMP;
          end
        end
        RARS_RAMP: begin
          // Classify on crossing or limit; log limit counts from ramp start
          if (ph1_tick) begin
            if (log_mode_select_r) begin
              if (!cmp_r) begin
                result_r <= RARS_RES_IN;
                state_r  <= RARS_FREEZE;
              end else if (elapsed_r == RARS_LOG_OVER_CNT) begin
                result_r <= RARS_RES_OVER;
                state_r  <= RARS_FREEZE;
              end
            end else if (!cmp_r) begin
              result_r <= (count_r < RARS_LIN_UNDER_CNT) ? RARS_RES_UNDER
                                                         : RARS_RES_IN;
              state_r  <= RARS_FREEZE;
            end else if (count_r == RARS_LIN_OVER_CNT) begin
              result_r <= RARS_RES_OVER;
              state_r  <= RARS_FREEZE;
            end
          end
        end
        RARS_FREEZE: begin
          // Wait for phase two to drop the drive
          if (ph2_tick) begin
            state_r <= RARS_CLR_RANGE;
          end
        end
        RARS_CLR_RANGE: begin
          if (log_mode_select_r) begin
            case (result_r)
              RARS_RES_UNDER: state_r <= RARS_SET_UNDER;
              RARS_RES_OVER: begin
                if (auto_range_r && range_r < RARS_RANGE_MAX) begin
                  range_r <= range_r + 3'h1;
                  state_r <= RARS_IDLE;
                end else begin
                  state_r <= RARS_SET_OVER;
                end
              end
              default: state_r <= RARS_XFER;
            endcase
          end else begin
            case (result_r)
              RARS_RES_UNDER: begin
                if (range_r == RARS_RANGE_MIN) begin
                  state_r <= RARS_XFER;
                end else if (auto_range_r) begin
                  state_r <= RARS_SET_OVER;
                end else begin
                  state_r <= RARS_SET_UNDER;
                end
              end
              RARS_RES_OVER: state_r <= RARS_SET_OVER;
              default:       state_r <= RARS_XFER;
            endcase
          end
        end
        RARS_SET_UNDER: begin
          state_r <= log_mode_select_r ? RARS_SET_OVER : RARS_XFER;
        end
        RARS_SET_OVER: begin
          if (!log_mode_select_r && auto_range_r && result_r == RARS_RES_UNDER) begin
            range_r <= range_r - 3'h1;
            state_r <= RARS_IDLE;
          end else if (!log_mode_select_r && auto_range_r &&
                       result_r == RARS_RES_OVER && range_r < RARS_RANGE_MAX) begin
            range_r <= range_r + 3'h1;
            state_r <= RARS_IDLE;
          end else begin
            state_r <= RARS_XFER;
          end
        end
        RARS_XFER: state_r <= RARS_IDLE;
        default:   state_r <= RARS_IDLE;
      endcase
      // Software range write while idle
      if (apb_wr && paddr == RARS_RANGE_OFS && state_r == RARS_IDLE) begin
        range_r <= pwdata[2:0];
      end
    end
  end

  // ============================================================
  // Over/under range decoder
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec_r <= '0;
    end else begin
      case (state_r)
        RARS_CLR_RANGE: dec_r <= '0;
        RARS_SET_OVER: begin
          dec_r.display_blank      <= 1'b1;
          dec_r.remote_over_status <= 1'b1;
          dec_r.over_indicator     <= 1'b1;
        end
        RARS_SET_UNDER: begin
          dec_r.remote_under_status <= 1'b1;
          dec_r.under_indicator     <= 1'b1;
          dec_r.over_indicator      <= 1'b0;
        end
        default: dec_r <= dec_r;
      endcase
    end
  end

  assign decoder = dec_r;

  // ============================================================
  // Transfer to display and remote
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp_r      <= RARS_ZERO_CNT;
      disp_sign_r <= 1'b0;
      rem_code_r  <= 2'h0;
      done_r      <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (state_r == RARS_XFER) begin
        disp_r      <= count_r;
        disp_sign_r <= sign_neg_r;
        done_r      <= 1'b1;
        // Status taken up only here
        rem_code_r  <= {dec_r.remote_over_status,
                        dec_r.remote_under_status};
      end
    end
  end

  // Blanked display keeps only the top digit
  assign display_value      = dec_r.display_blank ? {disp_r[15:12], 12'h000} : disp_r;
  assign display_sign_neg   = disp_sign_r;
  assign remote_status_code = rem_code_r;
  assign measure_done       = done_r;
  assign range              = range_r;

  // ============================================================
  // APB slave, zero wait states
  assign apb_wr  = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // Control and preset registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      log_mode_select_r <= 1'b0;
      auto_range_r      <= 1'b0;
      start_r           <= 1'b0;
      preset_r          <= RARS_PRESET_RST;
    end else begin
      if (state_r == RARS_IDLE && start_r) begin
        start_r <= 1'b0;
      end
      if (apb_wr && paddr == RARS_CTRL_OFS) begin
        start_r           <= pwdata[RARS_CTRL_START_BIT] | (start_r && state_r != RARS_IDLE);
        log_mode_select_r <= pwdata[RARS_CTRL_LOG_BIT];
        auto_range_r      <= pwdata[RARS_CTRL_AUTO_BIT];
      end
      if (apb_wr && paddr == RARS_PRESET_OFS) begin
        preset_r <= pwdata[16:0];
      end
    end
  end

  // Read mux
  always_comb begin
    case (paddr)
      RARS_CTRL_OFS:   prdata = {29'h0, auto_range_r, log_mode_select_r, start_r};
      RARS_RANGE_OFS:  prdata = {29'h0, range_r};
      RARS_PRESET_OFS: prdata = {15'h0, preset_r};
      RARS_STATUS_OFS: prdata = {19'h0, state_r, result_r, rem_code_r, dec_r};
      RARS_DISP_OFS:   prdata = {15'h0, disp_sign_r, disp_r};
      default:         prdata = 32'h0;
    endcase
  end

endmodule // rars_sequencer
`default_nettype wire

/* File: design/rars_pkg.sv */
// ============================================================
// Shared constants and types for the ramp range sequencer
package rars_pkg;

  // ============================================================
  // Register map (APB byte offsets)
  localparam logic [7:0] RARS_CTRL_OFS   = 8'h00;  // Control: start, mode, auto-range
  localparam logic [7:0] RARS_RANGE_OFS  = 8'h04;  // Range counter
  localparam logic [7:0] RARS_PRESET_OFS = 8'h08;  // Log preset value and sign
  localparam logic [7:0] RARS_STATUS_OFS = 8'h0c;  // Sequencer and decoder status
  localparam logic [7:0] RARS_DISP_OFS   = 8'h10;  // Display registers and sign

  // Control register bit positions
  localparam int RARS_CTRL_START_BIT = 0;  // Write 1 starts a conversion (self-clearing)
  localparam int RARS_CTRL_LOG_BIT   = 1;  // Log-mode select
  localparam int RARS_CTRL_AUTO_BIT  = 2;  // Auto-range enable

  // ============================================================
  // Count thresholds, as four BCD digits
  localparam logic [15:0] RARS_LIN_UNDER_CNT = 16'h0100;  // Linear under-range limit
  localparam logic [15:0] RARS_LIN_OVER_CNT  = 16'h1200;  // Linear over-range limit
  localparam logic [15:0] RARS_LOG_OVER_CNT  = 16'h1100;  // Log over-range limit
  localparam logic [15:0] RARS_ZERO_CNT      = 16'h0000;  // Cleared counter value

  // Range limits and reset values
  localparam logic [2:0]  RARS_RANGE_MIN   = 3'h1;   // Lowest range
  localparam logic [2:0]  RARS_RANGE_MAX   = 3'h5;   // Highest range
  localparam logic [2:0]  RARS_RANGE_RST   = 3'h5;   // Range after reset
  localparam logic [16:0] RARS_PRESET_RST  = 17'h00000; // Preset after reset

  // Phase-one divider: pclk cycles per phase-one pulse
  localparam int RARS_PH1_DIV = 4;

  // ============================================================
  // Sequencer states
  typedef enum logic [3:0] {
    RARS_IDLE,      // Waiting for a start
    RARS_CLEAR,     // Counter clear before every conversion
    RARS_PRESET,    // Preset from true-range value
    RARS_SAMPLE,    // Log comparator pre-check
    RARS_RAMP,      // Ramp-down counting
    RARS_FREEZE,    // Ramp drive held until phase two, counter frozen
    RARS_CLR_RANGE, // Decoder cleared
    RARS_SET_UNDER, // Set-under-range issued
    RARS_SET_OVER,  // Set-over-range issued
    RARS_XFER       // Transfer to display and remote
  } rars_state_type;

  // Result classes
  typedef enum logic [1:0] {
    RARS_RES_IN,
    RARS_RES_UNDER,
    RARS_RES_OVER
  } rars_result_type;

  // Decoder outputs, carried together
  typedef struct packed {
    logic display_blank;        // Active-high blank request
    logic remote_over_status;   // Remote over-range line
    logic remote_under_status;  // Remote under-range line
    logic over_indicator;       // Over-range lamp
    logic under_indicator;      // Under-range lamp
  } rars_decoder_type;

  // Ramp drives, carried together
  typedef struct packed {
    logic ramp_pos_drive;       // Positive ramp
    logic ramp_neg_drive;       // Negative ramp
    logic log_ramp_drive;       // Log slope ramp
    logic log_threshold_select; // Log threshold chosen
  } rars_drive_type;

endpackage

/* File: bench/rars_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ====================
// Port checker for the ramp range sequencer
module rars_monitor
  import rars_pkg::*;
(
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             auto_zero_active,
  input wire rars_drive_type   drive,
  input wire rars_decoder_type decoder,
  input wire logic [15:0]      display_value,
  input wire logic             display_sign_neg,
  input wire logic [1:0]       remote_status_code,
  input wire logic             measure_done
);
  // One clock domain, one reset
  default clocking mon_cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ====================
  // Assertions
  chk_blank_digits: assert property (decoder.display_blank |-> display_value[11:0] == 12'h000)
    else $error("lower digits shown while blanked");
  chk_drive_excl: assert property (!(drive.ramp_pos_drive && drive.ramp_neg_drive))
    else $error("both ramp polarities driven");
  chk_logramp_thr: assert property (drive.log_ramp_drive |-> drive.log_threshold_select)
    else $error("log ramp without log threshold");
  chk_thr_azero: assert property (auto_zero_active |-> !drive.log_threshold_select)
    else $error("log threshold during auto-zero");
  chk_over_sets: assert property ($rose(decoder.over_indicator)
    |-> decoder.display_blank && decoder.remote_over_status)
    else $error("over lamp without blank and remote over");
  chk_blank_remote: assert property (decoder.display_blank == decoder.remote_over_status)
    else $error("blank and remote over disagree");
  chk_under_pair: assert property (decoder.under_indicator == decoder.remote_under_status)
    else $error("under lamp and remote under disagree");
  chk_code_latch: assert property ($changed(remote_status_code) |-> ##[0:1] measure_done)
    else $error("remote code moved without transfer");
  chk_sign_latch: assert property ($changed(display_sign_neg) |-> ##[0:1] measure_done)
    else $error("display sign moved without transfer");
  chk_done_idle: assert property (measure_done
    |-> !(drive.ramp_pos_drive || drive.ramp_neg_drive || drive.log_ramp_drive))
    else $error("ramp still driven at completion");

  // Main scenarios reached
  cov_done: cover property (measure_done);
  cov_blank: cover property (decoder.display_blank);
  cov_log_ramp: cover property (drive.log_ramp_drive);
endmodule // rars_monitor

bind rars_sequencer rars_monitor mon_u (
  .pclk, .presetn, .auto_zero_active, .drive, .decoder, .display_value,
  .display_sign_neg, .remote_status_code, .measure_done
);
`default_nettype wire

/* File: bench/rars_adc_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ====================
// Analog ramp converter and threshold comparator
module rars_adc_model
  import rars_pkg::*;
(
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire rars_drive_type drive,
  input  wire logic [15:0]    cross_after,
  input  wire logic           charged,
  output logic                comparator_in
);
  logic [15:0] ramp_cnt_r;  // Cycles of ramp drive so far
  logic        ramping;     // Any ramp slope active

  assign ramping = drive.ramp_pos_drive | drive.ramp_neg_drive | drive.log_ramp_drive;

  // Ramp time, saturating, cleared when the drive drops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp_cnt_r <= 16'h0000;
    end else if (ramping) begin
      ramp_cnt_r <= (ramp_cnt_r == 16'hffff) ? ramp_cnt_r : ramp_cnt_r + 16'h0001;
    end else begin
      ramp_cnt_r <= 16'h0000;
    end
  end

  // High until the ramp passes threshold; charge level when not ramping
  assign comparator_in = (ramp_cnt_r != 16'h0000) ? (ramp_cnt_r < cross_after) : charged;
endmodule // rars_adc_model
`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ====================
// Self-checking bench for the ramp range sequencer
module tb_top;
  import rars_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        comparator_in, auto_zero_active, display_sign_neg, measure_done, charged;
  logic [15:0] display_value, cross_after;
  logic [1:0]  remote_status_code;
  logic [2:0]  range;
  rars_drive_type   drive;
  rars_decoder_type decoder;
  int bad_count = 0;
  int comparisons = 0;

  rars_sequencer #(.PH1_DIV(2)) dut_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .comparator_in, .auto_zero_active, .drive, .decoder, .display_value,
    .display_sign_neg, .remote_status_code, .measure_done, .range
  );
  rars_adc_model adc_u (.pclk, .presetn, .drive, .cross_after, .charged, .comparator_in);

  // Clock, 8 ns period
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // ====================
  // Shared tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Start one conversion and wait for completion or a range step
  task automatic convert(input logic [2:0] rng, input logic [31:0] ctl, input logic [15:0] crs,
                         input logic chg, input logic dn, input logic [2:0] rng_e,
                         input logic [6:0] res);
    logic [31:0] q;
    int n;
    cross_after <= crs;
    charged <= chg;
    apb(1'b1, RARS_RANGE_OFS, {29'h0, rng}, q);
    apb(1'b1, RARS_CTRL_OFS, ctl, q);
    n = 0;
    @(negedge pclk);
    while (measure_done !== 1'b1 && range === rng && n < 8000) begin
      @(negedge pclk);
      n++;
    end
    check("done", {31'h0, measure_done}, {31'h0, dn});
    check("range", {29'h0, range}, {29'h0, rng_e});
    if (dn) check("result", {25'h0, remote_status_code, decoder}, {25'h0, res});
    repeat (6) @(posedge pclk);
  endtask

  // ====================
  // Scenarios
  task automatic s_reset();
    logic [31:0] q;
    apb(1'b0, RARS_RANGE_OFS, 32'h0, q);
    check("range reset", q, 32'h5);
    apb(1'b0, 8'h14, 32'h0, q);
    check("unmapped", q, 32'h0);
    check("pslverr", {31'h0, pslverr}, 32'h0);
  endtask

  task automatic s_linear();
    convert(3'h3, 32'h1, 16'd1200, 1'b1, 1'b1, 3'h3, 7'h00);
    convert(3'h3, 32'h1, 16'd100, 1'b1, 1'b1, 3'h3, 7'h25);
    convert(3'h1, 32'h1, 16'd100, 1'b1, 1'b1, 3'h1, 7'h00);
    convert(3'h5, 32'h1, 16'hffff, 1'b1, 1'b1, 3'h5, 7'h5a);
    check("blank digits", {16'h0, display_value}, 32'h1000);
  endtask

  task automatic s_auto();
    convert(3'h3, 32'h5, 16'd100, 1'b1, 1'b0, 3'h2, 7'h00);
    check("auto blank", {31'h0, decoder.display_blank}, 32'h1);
    convert(3'h4, 32'h5, 16'hffff, 1'b1, 1'b0, 3'h5, 7'h00);
  endtask

  task automatic s_log();
    logic [31:0] q;
    convert(3'h3, 32'h3, 16'd200, 1'b0, 1'b1, 3'h3, 7'h7f);
    apb(1'b1, RARS_PRESET_OFS, 32'h10005, q);
    convert(3'h3, 32'h3, 16'd200, 1'b1, 1'b1, 3'h3, 7'h00);
    check("log sign", {31'h0, display_sign_neg}, 32'h0);
    convert(3'h5, 32'h3, 16'hffff, 1'b1, 1'b1, 3'h5, 7'h5a);
    check("log thr", {31'h0, drive.log_threshold_select}, 32'h1);
    auto_zero_active <= 1'b1;
    @(negedge pclk);
    check("thr azero", {31'h0, drive.log_threshold_select}, 32'h0);
    @(posedge pclk);
    auto_zero_active <= 1'b0;
  endtask

  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    auto_zero_active = 1'b0;
    charged = 1'b1;
    cross_after = 16'hffff;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    s_reset();
    s_linear();
    s_auto();
    s_log();
    tally_and_finish();
  end

  // Watchdog against a hang
  initial begin
    repeat (80000) @(posedge pclk);
    bad_count++;
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
